// [logic/stx_exec.sv]
`timescale 1ns/1ns
`include "stx_map.svh"
// How it works
// - Byte test skip: zero byte discards prefetched instruction, two cycles, else one.
// - Copy-and-skip loads byte into accumulator, skips likewise when byte zero.
// - Bit test skip: selected bit zero skips in two cycles, else one.
// - Current-page table read: low byte to memory, high byte to table_high_byte.
// - Final-page table read uses last ROM page, same byte placement.
// - Memory XOR writes accumulator xor byte to accumulator, memory untouched.
// - XOR into memory writes result back to the addressed byte.
// - Immediate XOR combines literal with accumulator into accumulator.
// - XOR forms update zero flag only; other flags stay.
module stx_exec
   import stx_pkg::*;
(
   // Clock and reset
   input  wire logic                      MCLK,
   input  wire logic                      RESETN,
   // Instruction issue
   input  wire stx_op_t                   OP,
   input  wire logic                      OP_VALID,
   input  wire logic [`STX_DATA_W-1:0]    MEM_DATA,
   input  wire logic [`STX_DATA_W-1:0]    LITERAL,
   input  wire logic [`STX_BIT_SEL_W-1:0] BIT_SEL,
   output logic                           BUSY,
   // Table access
   input  wire logic [`STX_DATA_W-1:0]    TABLE_POINTER,
   input  wire logic [`STX_PAGE_W-1:0]    CUR_PAGE,
   output logic [`STX_ROM_AW-1:0]         ROM_ADDR,
   output logic                           ROM_REQ,
   input  wire logic [`STX_ROM_W-1:0]     ROM_DATA,
   // Memory write-back
   output logic                           MEM_WE,
   output logic [`STX_DATA_W-1:0]         MEM_WDATA,
   // Core state
   output logic [`STX_DATA_W-1:0]         ACC,
   output logic [`STX_DATA_W-1:0]         TABLE_HIGH_BYTE,
   output logic [`STX_FLAGS_W-1:0]        STATUS,
   output logic                           DISCARD_NEXT
);
   // ==================================================
   // Shared test logic
   stx_alu_if alu_bus ();
   stx_alu u_alu (
      .a (alu_bus.alu)
   );

   logic [`STX_DATA_W-1:0] xor_src;
   assign xor_src         = (OP == STX_OP_XOR_IMMEDIATE) ? LITERAL : MEM_DATA;
   assign alu_bus.acc     = ACC;
   assign alu_bus.operand = xor_src;
   assign alu_bus.bit_sel = BIT_SEL;

   // ==================================================
   // Decode of the issued instruction
   wire issue   = OP_VALID && !BUSY;
   wire is_skb  = (OP == STX_OP_SKIP_IF_NULL);
   wire is_cps  = (OP == STX_OP_COPY_THEN_SKIP_IF_NULL);
   wire is_skbi = (OP == STX_OP_SKIP_IF_BIT_NULL);
   wire is_trc  = (OP == STX_OP_TABLE_READ_CURRENT_PAGE);
   wire is_trf  = (OP == STX_OP_TABLE_READ_FINAL_PAGE);
   wire is_xa   = (OP == STX_OP_XOR_INTO_ACC);
   wire is_xm   = (OP == STX_OP_XOR_INTO_MEMORY);
   wire is_xi   = (OP == STX_OP_XOR_IMMEDIATE);
   wire any_xor = is_xa || is_xm || is_xi;

   wire skip_hit = issue && (((is_skb || is_cps) && alu_bus.byte_null)
                             || (is_skbi && alu_bus.bit_null));
   wire tbl_go   = issue && (is_trc || is_trf);

   // ==================================================
   // Sequencer: dummy cycle after a skip, ROM wait for table reads
   stx_state_t state_r;
   stx_state_t state_nxt;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         STX_IDLE: begin
            if (skip_hit) begin
               state_nxt = STX_DUMMY;
            end else if (tbl_go) begin
               state_nxt = STX_ROM_WAIT;
            end
         end
         STX_ROM_WAIT: state_nxt = STX_IDLE;
         STX_DUMMY:    state_nxt = STX_IDLE;
         default:      state_nxt = STX_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= STX_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Handshake outputs are combinational
   assign BUSY         = (state_r != STX_IDLE);
   assign DISCARD_NEXT = (state_r == STX_DUMMY);

   // ==================================================
   // ROM address: page from current or last page
   logic [`STX_PAGE_W-1:0] page_sel_r;
   logic [`STX_DATA_W-1:0] tp_r;
   assign ROM_ADDR = {page_sel_r, tp_r};
   assign ROM_REQ  = (state_r == STX_ROM_WAIT);

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         page_sel_r <= '0;
         tp_r       <= '0;
      end else if (tbl_go) begin
         page_sel_r <= is_trf ? `STX_LAST_PAGE : CUR_PAGE;
         tp_r       <= TABLE_POINTER;
      end
   end

   // ==================================================
   // Accumulator, table high byte, flags, memory write
   wire rom_done = (state_r == STX_ROM_WAIT);

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ACC <= `STX_ACC_RST;
      end else if (issue && (is_xa || is_xi)) begin
         ACC <= alu_bus.xor_result;
      end else if (issue && is_cps) begin
         ACC <= MEM_DATA;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         TABLE_HIGH_BYTE <= `STX_TABLE_HIGH_BYTE_RST;
      end else if (rom_done) begin
         TABLE_HIGH_BYTE <= ROM_DATA[`STX_ROM_W-1:`STX_DATA_W];
      end
   end

   // Only Z is ever written here; other flags belong to the rest of the core
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         STATUS <= `STX_STATUS_RST;
      end else if (issue && any_xor) begin
         STATUS[`STX_FLAG_Z] <= alu_bus.xor_null;
      end
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         MEM_WE    <= 1'b0;
         MEM_WDATA <= 8'h00;
      end else if (rom_done) begin
         MEM_WE    <= 1'b1;
         MEM_WDATA <= ROM_DATA[`STX_DATA_W-1:0];
      end else if (issue && is_xm) begin
         MEM_WE    <= 1'b1;
         MEM_WDATA <= alu_bus.xor_result;
      end else begin
         MEM_WE    <= 1'b0;
      end
   end

   // ==================================================
   // Checks
   chk_skip_dummy: assert property (@(posedge MCLK) disable iff (!RESETN)
      skip_hit |=> DISCARD_NEXT ##1 !DISCARD_NEXT)
      else $error("skip did not give exactly one dummy cycle");
   chk_no_skip: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_skbi && !alu_bus.bit_null) |=> !DISCARD_NEXT && !BUSY)
      else $error("set bit caused a skip");
   chk_copy_acc: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_cps) |=> ACC == $past(MEM_DATA))
      else $error("copy-and-skip did not load accumulator");
   chk_tbl_high: assert property (@(posedge MCLK) disable iff (!RESETN)
      (tbl_go && is_trc) |=> ROM_REQ && ROM_ADDR == {$past(CUR_PAGE), $past(TABLE_POINTER)}
         ##1 TABLE_HIGH_BYTE == $past(ROM_DATA[15:8]) && MEM_WE)
      else $error("current-page table read wrong");
   chk_tbl_last: assert property (@(posedge MCLK) disable iff (!RESETN)
      (tbl_go && is_trf) |=> ROM_ADDR[12:8] == 5'h1F ##1 MEM_WDATA == $past(ROM_DATA[7:0]))
      else $error("final-page table read wrong");
   chk_xor_acc: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_xa) |=> ACC == ($past(ACC) ^ $past(MEM_DATA)) && !MEM_WE)
      else $error("memory xor into accumulator wrong");
   chk_xor_mem: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_xm) |=> MEM_WE && MEM_WDATA == ($past(ACC) ^ $past(MEM_DATA)) && $stable(ACC))
      else $error("xor into memory wrong");
   chk_xor_imm: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_xi) |=> ACC == ($past(ACC) ^ $past(LITERAL)))
      else $error("immediate xor wrong");
   chk_xor_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && any_xor) |=> STATUS[2] == ($past(is_xm) ? (MEM_WDATA == 8'h00) : (ACC == 8'h00))
         && STATUS[5:3] == $past(STATUS[5:3]) && STATUS[1:0] == $past(STATUS[1:0]))
      else $error("xor flag update wrong");
   chk_flags_kept: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && !any_xor) |=> $stable(STATUS))
      else $error("non-xor instruction changed flags");

   // ==================================================
   // Sequencing checks, so a stray busy cycle cannot hide
   chk_rom_pulse: assert property (@(posedge MCLK) disable iff (!RESETN)
      ROM_REQ |=> !ROM_REQ)
      else $error("ROM request held too long");
   chk_discard_cause: assert property (@(posedge MCLK) disable iff (!RESETN)
      DISCARD_NEXT |-> $past(skip_hit))
      else $error("dummy cycle without a skip");
   chk_busy_refuse: assert property (@(posedge MCLK) disable iff (!RESETN)
      BUSY |=> $stable(ACC) && $stable(STATUS))
      else $error("instruction taken while busy");
   chk_byte_no_skip: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && (is_skb || is_cps) && !alu_bus.byte_null) |=> !DISCARD_NEXT && !BUSY)
      else $error("non-zero byte caused a skip");
   chk_tbl_wait: assert property (@(posedge MCLK) disable iff (!RESETN)
      tbl_go |=> BUSY ##1 !BUSY)
      else $error("table read did not take one wait cycle");
   chk_tbl_state: assert property (@(posedge MCLK) disable iff (!RESETN)
      tbl_go |=> $stable(ACC) && $stable(STATUS) ##1 $stable(ACC) && $stable(STATUS))
      else $error("table read changed accumulator or flags");
   chk_imm_no_write: assert property (@(posedge MCLK) disable iff (!RESETN)
      (issue && is_xi) |=> !MEM_WE)
      else $error("immediate xor wrote memory");
endmodule

// [logic/stx_map.svh]
`ifndef STX_MAP_SVH
`define STX_MAP_SVH
// Widths
`define STX_DATA_W      8
`define STX_ROM_W       16
`define STX_ROM_AW      13
`define STX_PAGE_W      5
`define STX_BIT_SEL_W   3
// Status flag positions
`define STX_FLAG_C      0
`define STX_FLAG_AC     1
`define STX_FLAG_Z      2
`define STX_FLAG_OV     3
`define STX_FLAG_PDF    4
`define STX_FLAG_TO     5
`define STX_FLAGS_W     6
// Reset values
`define STX_ACC_RST     8'h00
`define STX_STATUS_RST  6'h00
`define STX_TABLE_HIGH_BYTE_RST    8'h00
// Last ROM page number
`define STX_LAST_PAGE   5'h1F
// Cycle counts
`define STX_SKIP_CYCLES 2
`define STX_RUN_CYCLES  1
`endif

// [logic/stx_pkg.sv]
package stx_pkg;
   typedef enum logic [3:0] {
      STX_OP_NONE,
      STX_OP_SKIP_IF_NULL,
      STX_OP_COPY_THEN_SKIP_IF_NULL,
      STX_OP_SKIP_IF_BIT_NULL,
      STX_OP_TABLE_READ_CURRENT_PAGE,
      STX_OP_TABLE_READ_FINAL_PAGE,
      STX_OP_XOR_INTO_ACC,
      STX_OP_XOR_INTO_MEMORY,
      STX_OP_XOR_IMMEDIATE
   } stx_op_t;

   typedef enum logic [1:0] {
      STX_IDLE,
      STX_ROM_WAIT,
      STX_DUMMY
   } stx_state_t;
endpackage

// [logic/stx_alu_if.sv]
`timescale 1ns/1ns
`include "stx_map.svh"
interface stx_alu_if;
   logic [`STX_DATA_W-1:0]    acc;
   logic [`STX_DATA_W-1:0]    operand;
   logic [`STX_BIT_SEL_W-1:0] bit_sel;
   logic [`STX_DATA_W-1:0]    xor_result;
   logic                      byte_null;
   logic                      bit_null;
   logic                      xor_null;

   modport core (output acc, output operand, output bit_sel,
                 input xor_result, input byte_null, input bit_null, input xor_null);
   modport alu  (input acc, input operand, input bit_sel,
                 output xor_result, output byte_null, output bit_null, output xor_null);
endinterface

// [logic/stx_alu.sv]
`timescale 1ns/1ns
`include "stx_map.svh"
module stx_alu
   import stx_pkg::*;
(
   stx_alu_if.alu         a
);
   // ==================================================
   // Tests and exclusive-or
   assign a.xor_result = a.acc ^ a.operand;
   assign a.xor_null   = (a.xor_result == 8'h00);
   assign a.byte_null  = (a.operand == 8'h00);
   assign a.bit_null   = ~a.operand[a.bit_sel];
endmodule

// [tb/skip_tableread_xor_exec_test.sv]
`timescale 1ns/1ns
`include "stx_map.svh"
module skip_tableread_xor_exec_test import stx_pkg::*;;
   typedef struct {
      stx_op_t    op;
      logic [7:0] mem, lit;
      logic [2:0] bs;
      logic [7:0] acc;
      logic       z, skip, we;
      logic [7:0] wd;
   } stx_row_t;
   logic        mclk, rstn, op_valid, busy, rom_req, mem_we, discard;
   stx_op_t     op;
   logic [7:0]  mem_data, literal, tptr, mem_wdata, acc, thb;
   logic [2:0]  bit_sel;
   logic [4:0]  cur_page;
   logic [12:0] rom_addr;
   logic [15:0] rom_data;
   logic [5:0]  status;
   int          err_count, n_checks;
   // ==========================================
   // Rows run in order, accumulator carried on
   stx_row_t rows [14] = '{
      '{STX_OP_XOR_IMMEDIATE, 8'h00, 8'h3C, 3'h0, 8'h3C, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_XOR_INTO_ACC, 8'h3C, 8'h00, 3'h0, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00},
      '{STX_OP_XOR_IMMEDIATE, 8'h00, 8'hA5, 3'h0, 8'hA5, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_XOR_INTO_MEMORY, 8'hA5, 8'h00, 3'h0, 8'hA5, 1'b1, 1'b0, 1'b1, 8'h00},
      '{STX_OP_XOR_INTO_MEMORY, 8'h0F, 8'h00, 3'h0, 8'hA5, 1'b0, 1'b0, 1'b1, 8'hAA},
      '{STX_OP_SKIP_IF_NULL, 8'h00, 8'h00, 3'h0, 8'hA5, 1'b0, 1'b1, 1'b0, 8'h00},
      '{STX_OP_SKIP_IF_NULL, 8'h01, 8'h00, 3'h0, 8'hA5, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_COPY_THEN_SKIP_IF_NULL, 8'h00, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00},
      '{STX_OP_COPY_THEN_SKIP_IF_NULL, 8'h80, 8'h00, 3'h0, 8'h80, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_SKIP_IF_BIT_NULL, 8'hF7, 8'h00, 3'h3, 8'h80, 1'b0, 1'b1, 1'b0, 8'h00},
      '{STX_OP_SKIP_IF_BIT_NULL, 8'h08, 8'h00, 3'h3, 8'h80, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_SKIP_IF_BIT_NULL, 8'h7F, 8'h00, 3'h7, 8'h80, 1'b0, 1'b1, 1'b0, 8'h00},
      '{STX_OP_NONE, 8'h00, 8'hFF, 3'h0, 8'h80, 1'b0, 1'b0, 1'b0, 8'h00},
      '{STX_OP_XOR_IMMEDIATE, 8'h00, 8'h80, 3'h0, 8'h00, 1'b1, 1'b0, 1'b0, 8'h00}};

   stx_exec DUT (.MCLK(mclk), .RESETN(rstn), .OP(op), .OP_VALID(op_valid), .MEM_DATA(mem_data),
      .LITERAL(literal), .BIT_SEL(bit_sel), .BUSY(busy), .TABLE_POINTER(tptr), .CUR_PAGE(cur_page),
      .ROM_ADDR(rom_addr), .ROM_REQ(rom_req), .ROM_DATA(rom_data), .MEM_WE(mem_we),
      .MEM_WDATA(mem_wdata), .ACC(acc), .TABLE_HIGH_BYTE(thb), .STATUS(status), .DISCARD_NEXT(discard));

   // Word depends on every address bit, so a wrong page shows
   function automatic logic [15:0] rom_word(input logic [12:0] a);
      return {3'h5, a} ^ 16'h00FF;
   endfunction
   assign rom_data = rom_word(rom_addr);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // ==========================================
   // Checking and closing
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic issue(input stx_op_t o, input logic [7:0] m, input logic [7:0] l, input logic [2:0] b);
      @(posedge mclk);
      op <= o; mem_data <= m; literal <= l; bit_sel <= b; op_valid <= 1'b1;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic table_read(input stx_op_t o, input logic [4:0] pg, input logic [7:0] p, input logic [12:0] ea);
      @(posedge mclk);
      op <= o; cur_page <= pg; tptr <= p; op_valid <= 1'b1;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      check("rom_req", rom_req, 1'b1);
      check("rom_addr", rom_addr, ea);
      @(posedge mclk);
      #1;
      check("mem_we", mem_we, 1'b1);
      check("mem_wdata", mem_wdata, rom_word(ea) & 16'h00FF);
      check("thb", thb, rom_word(ea) >> 8);
      check("status", status, 6'h00);
      $display("test table read done");
   endtask
   // Roughly 60 cycles needed; generous margin
   initial begin
      #20000;
      err_count++;
      stop_test();
   end
   // ==========================================
   // Main sequence
   initial begin
      err_count = 0; n_checks = 0; rstn = 1'b0; op = STX_OP_NONE; op_valid = 1'b0;
      mem_data = 8'h00; literal = 8'h00; bit_sel = 3'h0; tptr = 8'h00; cur_page = 5'h00;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      #1;
      check("acc", acc, 8'h00);
      check("status", status, 6'h00);
      check("busy", busy, 1'b0);
      $display("test reset done");
      foreach (rows[i]) begin
         issue(rows[i].op, rows[i].mem, rows[i].lit, rows[i].bs);
         check("acc", acc, rows[i].acc);
         check("status", status, {3'h0, rows[i].z, 2'h0});
         check("mem_we", mem_we, rows[i].we);
         if (rows[i].we) check("mem_wdata", mem_wdata, rows[i].wd);
         check("discard", discard, rows[i].skip);
         if (rows[i].skip) begin
            check("busy", busy, 1'b1);
            @(posedge mclk);
            #1;
            check("busy", busy, 1'b0);
         end
      end
      $display("test rows done");
      @(posedge mclk);
      op <= STX_OP_XOR_IMMEDIATE; literal <= 8'h11; op_valid <= 1'b1;
      @(posedge mclk);
      literal <= 8'h22;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      check("acc", acc, 8'h33);
      $display("test back to back done");
      @(posedge mclk);
      op <= STX_OP_SKIP_IF_NULL; mem_data <= 8'h00; op_valid <= 1'b1;
      @(posedge mclk);
      op <= STX_OP_XOR_IMMEDIATE; literal <= 8'hFF;
      @(posedge mclk);
      op_valid <= 1'b0;
      #1;
      check("acc", acc, 8'h33);
      check("discard", discard, 1'b0);
      $display("test refused during skip done");
      table_read(STX_OP_TABLE_READ_CURRENT_PAGE, 5'h03, 8'h5A, {5'h03, 8'h5A});
      table_read(STX_OP_TABLE_READ_FINAL_PAGE, 5'h03, 8'hA7, {`STX_LAST_PAGE, 8'hA7});
      table_read(STX_OP_TABLE_READ_CURRENT_PAGE, 5'h1E, 8'hFF, {5'h1E, 8'hFF});
      check("acc", acc, 8'h33);
      @(posedge mclk);
      rstn <= 1'b0;
      #1;
      check("acc", acc, 8'h00);
      check("thb", thb, 8'h00);
      check("status", status, 6'h00);
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      check("busy", busy, 1'b0);
      check("discard", discard, 1'b0);
      issue(STX_OP_XOR_IMMEDIATE, 8'h00, 8'h5A, 3'h0);
      check("acc", acc, 8'h5A);
      check("status", status, 6'h00);
      $display("test mid reset done");
      stop_test();
   end
endmodule
